/* design/fdh_drive_if.sv */
/*
 * fdh_drive_if: host-interface control logic of a daisy-chained flexible
 * disk drive, with an APB slave for configuration and status.
 * Assumes host pins and mechanism sensors are asynchronous to pclk, that
 * open-collector outputs are resolved outside from the enables, and that
 * the mechanism carries out the head, spindle and write commands given.
 */
// The APB register port and the register offsets were decided locally.
// Functional notes
// - answer only the select line matching the single strap that is on
// - only run request, in-use and rate act while the unit is deselected
// - spindle reaches speed within 400 ms; request void without medium
// - direction high steps outward, low inward; held 0.8 us before edge
// - one track per step pulse, starting at its trailing edge
// - ignore steps while writing unlocked; ignore outward steps at track 0
// - write mode only with window true, selected and not write locked
// - write pulses used at leading edge, ignored when window shut or locked
// - surface high selects side 0; reads valid 100 us after a change
// - read pulses only when detected, selected, ready, 650 us after write
// - read pulses active low, 0.15 to 1.0 us wide
// - outer track flag true on the outermost track
// - one revolution mark per turn, 1 to 5.5 ms, selected and ready
// - ready needs power, chucked medium, 400 ms request, speed, two marks
// - ready drops fast on request loss; not ready holds pulses off
// - swap flag set at power-on or removal, cleared by a selected step
// - rate line high means high density, low doubles bit intervals; the code takes low_rate_mode high as the low rate
// - insertion spins the spindle to chuck within 750 ms
// - internal reset under 100 ms; no write without the window
// - every interface line is active low
// - status line carries swap flag, ready, or nothing by strap
`timescale 1ns/1ps
module fdh_drive_if #(
  parameter int unsigned POR_N    = fdh_pkg::POR_CYC,
  parameter int unsigned SPIN_N   = fdh_pkg::SPIN_CYC,
  parameter int unsigned CHUCK_N  = fdh_pkg::CHUCK_CYC,
  parameter int unsigned WREC_N   = fdh_pkg::WREC_CYC,
  parameter int unsigned SETTLE_N = fdh_pkg::SETTLE_CYC,
  parameter int unsigned USABLE_N = fdh_pkg::USABLE_CYC,
  parameter int unsigned OUTER_N  = fdh_pkg::OUTER_CYC,
  parameter int unsigned SIDE_N   = fdh_pkg::SIDE_CYC,
  parameter int unsigned INDEX_N  = fdh_pkg::INDEX_CYC
) (
  input  wire logic              pclk,     // 100 MHz clock
  input  wire logic              presetn,  // async reset, active low
  input  wire logic              psel,     // apb select
  input  wire logic              penable,  // apb access phase
  input  wire logic              pwrite,   // apb direction
  input  wire logic [11:0]       paddr,    // apb byte address
  input  wire logic [31:0]       pwdata,   // apb write data
  output logic                   pready,   // apb ready
  output logic [31:0]            prdata,   // apb read data
  output logic                   pslverr,  // apb error, unmapped address
  input  wire fdh_pkg::fdh_pins_t pins,    // host pins and sensors, async
  output fdh_pkg::fdh_hout_t     hout_o,   // open-collector levels, low
  output fdh_pkg::fdh_hout_t     hout_oe,  // high while pin pulled low
  output fdh_pkg::fdh_mech_t     mech      // commands to the mechanism
);
  import fdh_pkg::*;

  localparam logic [CNT_W-1:0] POR_C    = CNT_W'(POR_N);
  localparam logic [CNT_W-1:0] SPIN_C   = CNT_W'(SPIN_N);
  localparam logic [CNT_W-1:0] CHUCK_C  = CNT_W'(CHUCK_N);
  localparam logic [CNT_W-1:0] WREC_C   = CNT_W'(WREC_N);
  localparam logic [CNT_W-1:0] SETTLE_C = CNT_W'(SETTLE_N);
  localparam logic [CNT_W-1:0] USABLE_C = CNT_W'(USABLE_N);
  localparam logic [CNT_W-1:0] OUTER_C  = CNT_W'(OUTER_N);
  localparam logic [CNT_W-1:0] SIDE_C   = CNT_W'(SIDE_N);
  localparam logic [CNT_W-1:0] INDEX_C  = CNT_W'(INDEX_N);
  localparam logic [CNT_W-1:0] READ_C   = CNT_W'(READ_CYC);

  fdh_state_t st;
  fdh_state_t next_st;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // decoded view of the synchronised pins
  fdh_pins_t  p;
  fdh_pins_t  q;
  logic       strap_one;
  logic       selected;
  logic       run_req;
  logic       wgate;
  logic       step_trail;
  logic       wdata_lead;
  logic       read_start;
  logic       index_start;
  logic       step_blocked;
  logic       step_ok;
  logic       spindle_on;
  logic       ready;
  logic       write_mode;
  logic       wrec_done;
  logic       side_done;
  logic       usable;
  logic       rev_active;
  logic       read_active;
  logic       apb_write;
  logic       addr_hit;

  always_comb begin
    p          = st.sync2;
    q          = st.prev;
    // exactly one strap on, and the line with that number true
    strap_one  = $onehot(p.unit_address_straps);
    selected   = st.por_done && strap_one &&
                 |(p.unit_address_straps & ~p.unit_select_n);
    run_req    = !p.spindle_run_request_n;
    wgate      = !p.write_enable_window_n;
    // trailing edge of a low step pulse is its rising edge
    step_trail = p.step_n && !q.step_n;
    wdata_lead = !p.write_data_n && q.write_data_n;
    read_start = p.read_det && !q.read_det;
    index_start = p.index_det && !q.index_det;
    step_blocked = (wgate && !p.wp_tab) ||
                   (p.head_move_dir && st.track == 7'h00) ||
                   (!p.head_move_dir && st.track >= st.track_limit);
    step_ok    = selected && step_trail && !step_blocked;
    // medium gates the request; insertion chucks on its own
    spindle_on = st.por_done && p.disk_in &&
                 (run_req || !st.chucked);
    ready      = st.por_done && p.disk_in && st.chucked &&
                 run_req && st.spin >= SPIN_C &&
                 p.speed_ok && st.revs == 2'd2;
    write_mode = wgate && selected && !p.wp_tab;
    wrec_done  = !wgate && st.wrec >= WREC_C;
    side_done  = st.side >= SIDE_C;
    usable     = st.settle >= USABLE_C;
    rev_active = st.idx != '0;
    read_active = st.rd != '0;
    apb_write  = psel && penable && pwrite;
    addr_hit   = paddr == CTRL_ADDR || paddr == STATUS_ADDR;
  end

  always_comb begin
    next_st       = st;
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;

    // internal power-on reset
    next_st.por = sat_inc(st.por);
    if (st.por >= POR_C) begin
      next_st.por_done = 1'b1;
    end

    // run time since the request, only with medium present
    if (run_req && p.disk_in && st.por_done) begin
      next_st.spin = sat_inc(st.spin);
    end else begin
      next_st.spin = '0;
    end

    // auto-chuck after insertion, restarted by every insertion
    if (!p.disk_in) begin
      next_st.chucked = 1'b0;
      next_st.chuck   = '0;
    end else if (!st.chucked && st.por_done) begin
      next_st.chuck = sat_inc(st.chuck);
      if (st.chuck >= CHUCK_C) begin
        next_st.chucked = 1'b1;
      end
    end

    // revolution marks counted while the spindle is at speed
    if (!spindle_on || !p.speed_ok) begin
      next_st.revs = 2'd0;
    end else if (index_start && st.revs != 2'd2) begin
      next_st.revs = st.revs + 2'd1;
    end

    // write recovery counter
    if (wgate) begin
      next_st.wrec = '0;
    end else begin
      next_st.wrec = sat_inc(st.wrec);
    end

    // settle after the last effective step
    if (step_ok) begin
      next_st.settle = '0;
      if (p.head_move_dir) begin
        next_st.track = st.track - 7'd1;
      end else begin
        next_st.track = st.track + 7'd1;
      end
    end else begin
      next_st.settle = sat_inc(st.settle);
    end

    // side change restarts the read settle
    if (p.surface_select != q.surface_select) begin
      next_st.side = '0;
    end else begin
      next_st.side = sat_inc(st.side);
    end

    // revolution mark stretch, cut short when ready drops
    if (!ready || !selected) begin
      next_st.idx = '0;
    end else if (index_start) begin
      next_st.idx = INDEX_C;
    end else if (rev_active) begin
      next_st.idx = st.idx - 1'b1;
    end

    // read pulse stretch
    if (!ready || !selected || wgate) begin
      next_st.rd = '0;
    end else if (read_start && wrec_done && side_done) begin
      next_st.rd = READ_C;
    end else if (read_active) begin
      next_st.rd = st.rd - 1'b1;
    end

    // swap flag: setting wins over a clear in the same cycle
    if (selected && step_trail && p.disk_in) begin
      next_st.swapped = 1'b0;
    end
    if (!st.por_done || (!p.disk_in && q.disk_in)) begin
      next_st.swapped = 1'b1;
    end

    if (apb_write && paddr == CTRL_ADDR) begin
      next_st.track_limit = pwdata[6:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st             <= '0;
      st.sync1       <= '1;
      st.sync2       <= '1;
      st.prev        <= '1;
      st.swapped     <= 1'b1;
      st.track_limit <= TRACK_LIMIT_RST;
    end else begin
      st <= next_st;
    end
  end

  // apb slave: zero wait, error on unmapped addresses
  always_comb begin
    pready  = 1'b1;
    pslverr = psel && penable && !addr_hit;
    prdata  = 32'h0000_0000;
    if (psel && !pwrite && paddr == CTRL_ADDR) begin
      prdata[6:0] = st.track_limit;
    end else if (psel && !pwrite && paddr == STATUS_ADDR) begin
      prdata[6:0]  = st.track;
      prdata[8]    = ready;
      prdata[9]    = st.swapped;
      prdata[10]   = spindle_on;
      prdata[11]   = st.chucked;
      prdata[12]   = write_mode;
      prdata[13]   = selected;
      prdata[14]   = st.settle >= SETTLE_C;
      prdata[15]   = st.settle >= OUTER_C;
      prdata[16]   = usable;
      prdata[17]   = st.por_done;
    end
  end

  // host outputs: open collector, pulled low only while selected
  always_comb begin
    hout_o  = '0;
    hout_oe = '0;
    if (selected) begin
      hout_oe.rev_mark_pulse_n   = rev_active;
      hout_oe.read_pulse_n       = read_active;
      hout_oe.outer_track_flag_n = st.track == 7'h00;
      hout_oe.media_write_lock_n = p.wp_tab;
      if (p.swap_output_strap) begin
        hout_oe.status_n = st.swapped;
      end else if (p.ready_output_strap) begin
        hout_oe.status_n = ready;
      end
    end
  end

  // mechanism commands
  always_comb begin
    mech.spindle_on   = spindle_on;
    mech.head_step    = step_ok;
    mech.head_outward = p.head_move_dir;
    mech.head_side1   = selected && !p.surface_select;
    mech.write_mode   = write_mode;
    mech.write_flux   = write_mode && wdata_lead;
    mech.rate_normal  = !p.low_rate_mode;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_select_match: assert property (
    selected |-> $onehot(p.unit_address_straps) &&
                 (p.unit_address_straps & p.unit_select_n) == 4'h0)
    else $error("selected without matching strap and line");
  chk_desel_quiet: assert property (
    !selected |-> hout_oe == '0 && !mech.write_mode && !mech.head_step)
    else $error("outputs active while deselected");
  chk_step_block: assert property (
    (wgate && !p.wp_tab) || (p.head_move_dir && st.track == 7'h00)
      |-> !mech.head_step)
    else $error("step taken while blocked");
  chk_step_track: assert property (
    mech.head_step && !p.head_move_dir |=> st.track == $past(st.track) + 7'd1)
    else $error("inward step did not move one track");
  chk_write_cond: assert property (
    mech.write_mode |-> wgate && selected && !p.wp_tab)
    else $error("write mode without window, select or unlocked medium");
  chk_flux_gate: assert property (
    mech.write_flux |-> !p.write_data_n && q.write_data_n && !p.wp_tab)
    else $error("write flux not at leading edge or locked");
  chk_read_width: assert property (
    $rose(hout_oe.read_pulse_n) && ready && selected
      |-> hout_oe.read_pulse_n [*8])
    else $error("read pulse shorter than expected");
  chk_notready_quiet: assert property (
    !ready |=> !hout_oe.rev_mark_pulse_n && !hout_oe.read_pulse_n)
    else $error("pulse output while not ready");
  chk_ready_drop: assert property (
    !run_req |-> !ready)
    else $error("ready held without run request");
  chk_swap_set: assert property (
    !p.disk_in && q.disk_in |=> st.swapped)
    else $error("swap flag not set on removal");
  chk_outer_flag: assert property (
    selected |-> hout_oe.outer_track_flag_n == (st.track == 7'h00))
    else $error("outer track flag wrong");
  chk_status_sel: assert property (
    selected && !p.swap_output_strap && !p.ready_output_strap
      |-> !hout_oe.status_n)
    else $error("status driven with both straps off");
  chk_step_out: assert property (
    mech.head_step && p.head_move_dir |=> st.track == $past(st.track) - 7'd1)
    else $error("outward step did not move one track");
  chk_step_once: assert property (
    mech.head_step |=> !mech.head_step)
    else $error("one step pulse moved the head twice");
  chk_swap_clear: assert property (
    selected && step_trail && p.disk_in |=> !st.swapped)
    else $error("swap flag not cleared by selected step");
  chk_spin_medium: assert property (
    !p.disk_in |-> !mech.spindle_on)
    else $error("spindle running without medium");
  chk_flux_shut: assert property (
    !wgate || p.wp_tab |-> !mech.write_flux)
    else $error("write flux while window shut or locked");

  cov_step: cover property (step_ok);
  cov_ready: cover property ($rose(ready));
  cov_write: cover property (mech.write_flux);
  cov_read: cover property ($rose(hout_oe.read_pulse_n));
  cov_swap: cover property ($fell(st.swapped));
endmodule

/* design/fdh_pkg.sv */
/*
 * fdh_pkg: shared types and constants of the flexible disk drive host
 * interface block: pin groups, mechanism signals, the state record, the
 * register map and timing figures.
 * Assumes a 100 MHz pclk; every time is given in its own unit and turned
 * into cycles here.
 */
package fdh_pkg;

  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned CNT_W        = 27;

  // timing figures, each in its own unit
  localparam int unsigned POR_MS       = 90;
  localparam int unsigned SPIN_MS      = 400;
  localparam int unsigned CHUCK_MS     = 750;
  localparam int unsigned WREC_US      = 650;
  localparam int unsigned SETTLE_MS    = 18;
  localparam int unsigned USABLE_MS    = 6;
  localparam int unsigned OUTER_US     = 2800;
  localparam int unsigned SIDE_US      = 100;
  localparam int unsigned INDEX_US     = 2000;
  localparam int unsigned READ_NS      = 300;

  // cycle counts derived from the figures
  localparam int unsigned POR_CYC      = POR_MS * CLK_MHZ * 1000;
  localparam int unsigned SPIN_CYC     = SPIN_MS * CLK_MHZ * 1000;
  localparam int unsigned CHUCK_CYC    = CHUCK_MS * CLK_MHZ * 1000;
  localparam int unsigned WREC_CYC     = WREC_US * CLK_MHZ;
  localparam int unsigned SETTLE_CYC   = SETTLE_MS * CLK_MHZ * 1000;
  localparam int unsigned USABLE_CYC   = USABLE_MS * CLK_MHZ * 1000;
  localparam int unsigned OUTER_CYC    = OUTER_US * CLK_MHZ;
  localparam int unsigned SIDE_CYC     = SIDE_US * CLK_MHZ;
  localparam int unsigned INDEX_CYC    = INDEX_US * CLK_MHZ;
  localparam int unsigned READ_CYC     = READ_NS * CLK_MHZ / 1000;

  // register map
  localparam logic [11:0] CTRL_ADDR    = 12'h000;
  localparam logic [11:0] STATUS_ADDR  = 12'h004;
  localparam logic [6:0]  TRACK_LIMIT_RST = 7'h4F;

  // every input that crosses in from outside the clock domain
  typedef struct packed {
    logic [3:0] unit_select_n;
    logic       spindle_run_request_n;
    logic       head_move_dir;
    logic       step_n;
    logic       write_data_n;
    logic       write_enable_window_n;
    logic       surface_select;
    logic       low_rate_mode;
    logic [3:0] unit_address_straps;
    logic       swap_output_strap;
    logic       ready_output_strap;
    logic       disk_in;
    logic       wp_tab;
    logic       index_det;
    logic       read_det;
    logic       speed_ok;
  } fdh_pins_t;

  // open-collector host outputs, one bit per pin
  typedef struct packed {
    logic rev_mark_pulse_n;
    logic read_pulse_n;
    logic outer_track_flag_n;
    logic media_write_lock_n;
    logic status_n;
  } fdh_hout_t;

  // commands to the mechanism and head electronics
  typedef struct packed {
    logic spindle_on;
    logic head_step;
    logic head_outward;
    logic head_side1;
    logic write_mode;
    logic write_flux;
    logic rate_normal;
  } fdh_mech_t;

  typedef struct packed {
    fdh_pins_t        sync1;
    fdh_pins_t        sync2;
    fdh_pins_t        prev;
    logic             por_done;
    logic [CNT_W-1:0] por;
    logic [CNT_W-1:0] spin;
    logic [CNT_W-1:0] chuck;
    logic             chucked;
    logic [CNT_W-1:0] wrec;
    logic [CNT_W-1:0] settle;
    logic [CNT_W-1:0] side;
    logic [CNT_W-1:0] idx;
    logic [CNT_W-1:0] rd;
    logic [1:0]       revs;
    logic [6:0]       track;
    logic [6:0]       track_limit;
    logic             swapped;
  } fdh_state_t;

endpackage

/* verif/fdh_host_model.sv */
/* fdh_host_model: host controller and mechanism sensors facing the drive.
   Assumes the bench sets straps, selects and levels; spacing is scaled. */
`timescale 1ns/1ps
module fdh_host_model #(
  parameter int unsigned GAP_SAME = 300, // scaled same-way spacing
  parameter int unsigned GAP_TURN = 600  // scaled turn-round spacing
) (
  input  wire logic               pclk, // bench clock
  input  wire fdh_pkg::fdh_pins_t lv,   // levels and straps from the bench
  output fdh_pkg::fdh_pins_t      pins  // host lines and sensors
);
  import fdh_pkg::*;
  logic last_out = 1'b1;
  logic dir_out  = 1'b1;
  logic step_n   = 1'b1;
  logic wdata_n  = 1'b1;
  logic rd_det   = 1'b0;
  logic idx_det  = 1'b0;

  // pulse lines and the step direction belong to the tasks below, every other level to the bench
  always_comb begin
    pins               = lv;
    pins.head_move_dir = dir_out;
    pins.step_n        = step_n;
    pins.write_data_n  = wdata_n;
    pins.read_det      = rd_det;
    pins.index_det     = idx_det;
  end

  task automatic step(input logic out);
    repeat ((out == last_out) ? GAP_SAME : GAP_TURN) @(posedge pclk);
    dir_out <= out;
    step_n <= 1'b0;
    repeat (81) @(posedge pclk);
    step_n <= 1'b1;
    last_out = out;
  endtask

  // 0.1 us, inside the legal pulse band
  task automatic wr_pulse();
    @(posedge pclk);
    wdata_n <= 1'b0;
    repeat (10) @(posedge pclk);
    wdata_n <= 1'b1;
  endtask

  task automatic sense(input logic rd);
    @(posedge pclk);
    rd_det <= rd;
    idx_det <= !rd;
    repeat (4) @(posedge pclk);
    rd_det <= 1'b0;
    idx_det <= 1'b0;
  endtask
endmodule

/* verif/tb.sv */
/* tb: self-checking bench of the drive interface with a host model.
   Assumes shortened counts on the design and a 100 MHz pclk. */
`timescale 1ns/1ps
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin \
  num_errors++; $display("wrong value %s exp %0h got %0h", nm, e, a); end end
module tb;
  import fdh_pkg::*;
  typedef struct packed {
    logic        err;
    logic [31:0] m;
    logic [31:0] e;
  } fdh_note_t;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  fdh_pins_t   pins;
  fdh_pins_t   lv;
  fdh_hout_t   hout_o;
  fdh_hout_t   hout_oe;
  fdh_mech_t   mech;
  fdh_note_t   nt;
  fdh_note_t   exp_rd[$];
  logic        exp_dir[$];
  int          num_errors = 0;
  int          tests_run = 0;
  int          flux_cnt = 0;
  int          unit;

  fdh_drive_if #(.POR_N(50), .SPIN_N(40), .CHUCK_N(60), .WREC_N(20),
    .SETTLE_N(100), .USABLE_N(30), .OUTER_N(15), .SIDE_N(10),
    .INDEX_N(16)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .pins(pins),
    .hout_o(hout_o), .hout_oe(hout_oe), .mech(mech));
  fdh_host_model hm (.pclk(pclk), .lv(lv), .pins(pins));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic [31:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) exp_rd.push_back({a != CTRL_ADDR && a != STATUS_ADDR, m, e});
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // read data taken at the edge that completes the access
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_rd.size() > 0) begin
      nt = exp_rd.pop_front();
      `CHK("prdata", nt.e & nt.m, prdata & nt.m)
      `CHK("pslverr", nt.err, pslverr)
    end
    if (mech.head_step === 1'b1) begin
      if (exp_dir.size() == 0) `CHK("stray step", 1'b0, 1'b1)
      else `CHK("step dir", exp_dir.pop_front(), mech.head_outward)
    end
    if (mech.write_flux === 1'b1) flux_cnt++;
  end

  initial begin
    cyc(30000);
    num_errors++;
    summarize();
  end

  initial begin
    void'($urandom(32729));
    unit = $urandom % 4;
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= '0;
    pwdata <= '0;
    // host lines idle high, sensors quiet, own unit strapped
    lv <= {4'hF, 7'h7F, 4'(1 << unit), 1'b0, 1'b1, 5'h00};
    cyc(12);
    presetn <= 1'b1;
    apb(1'b0, CTRL_ADDR, '0, '1, 32'h4F);
    apb(1'b0, 12'h008, '0, '1, '0);
    apb(1'b1, STATUS_ADDR, '1, '0, '0);
    cyc(60);
    apb(1'b0, STATUS_ADDR, '0, 32'h20200, 32'h20200);
    lv.wp_tab <= 1'b1;
    lv.disk_in <= 1'b1;
    lv.unit_select_n <= ~4'(1 << ((unit + 1) % 4));
    cyc(8);
    `CHK("foreign unit", 5'h0, hout_oe)
    `CHK("oc level", 5'h0, hout_o)
    lv.unit_select_n <= ~4'(1 << unit);
    cyc(50);
    `CHK("lock oe", 1'b1, hout_oe.media_write_lock_n)
    `CHK("chuck spin", 1'b1, mech.spindle_on)
    cyc(70);
    apb(1'b0, STATUS_ADDR, '0, 32'hE7F, 32'hA00);
    hm.step(1'b1);
    repeat (2) begin
      exp_dir.push_back(1'b0);
      hm.step(1'b0);
    end
    cyc(20);
    apb(1'b0, STATUS_ADDR, '0, 32'h27F, 32'h002);
    `CHK("outer off", 1'b0, hout_oe.outer_track_flag_n)
    repeat (2) begin
      exp_dir.push_back(1'b1);
      hm.step(1'b1);
    end
    cyc(20);
    `CHK("outer on", 1'b1, hout_oe.outer_track_flag_n)
    cyc(90);
    lv.write_enable_window_n <= 1'b0;
    cyc(8);
    `CHK("wmode lock", 1'b0, mech.write_mode)
    exp_dir.push_back(1'b0);
    hm.step(1'b0);
    hm.wr_pulse();
    lv.wp_tab <= 1'b0;
    cyc(8);
    `CHK("wmode", 1'b1, mech.write_mode)
    hm.step(1'b0);
    hm.wr_pulse();
    cyc(8);
    `CHK("flux", 1, flux_cnt)
    lv.write_enable_window_n <= 1'b1;
    hm.wr_pulse();
    cyc(30);
    `CHK("flux shut", 1, flux_cnt)
    `CHK("wmode off", 1'b0, mech.write_mode)
    lv.spindle_run_request_n <= 1'b0;
    lv.speed_ok <= 1'b1;
    cyc(50);
    `CHK("spin", 1'b1, mech.spindle_on)
    apb(1'b0, STATUS_ADDR, '0, 32'h100, '0);
    hm.sense(1'b0);
    cyc(10);
    hm.sense(1'b0);
    cyc(10);
    apb(1'b0, STATUS_ADDR, '0, 32'h100, 32'h100);
    `CHK("status oe", 1'b1, hout_oe.status_n)
    hm.sense(1'b0);
    cyc(4);
    `CHK("mark", 1'b1, hout_oe.rev_mark_pulse_n)
    cyc(20);
    `CHK("mark end", 1'b0, hout_oe.rev_mark_pulse_n)
    hm.sense(1'b1);
    cyc(2);
    `CHK("read oe", 1'b1, hout_oe.read_pulse_n)
    cyc(40);
    `CHK("read end", 1'b0, hout_oe.read_pulse_n)
    lv.spindle_run_request_n <= 1'b1;
    cyc(8);
    `CHK("ready drop", 1'b0, hout_oe.status_n)
    hm.sense(1'b0);
    cyc(4);
    `CHK("mark gated", 1'b0, hout_oe.rev_mark_pulse_n)
    lv.low_rate_mode <= 1'b0;
    lv.surface_select <= 1'b0;
    cyc(8);
    `CHK("rate", 1'b1, mech.rate_normal)
    `CHK("side", 1'b1, mech.head_side1)
    // innermost limit at track 1: the next inward step must be refused
    apb(1'b1, CTRL_ADDR, {25'($urandom), 7'h01}, '0, '0);
    apb(1'b0, CTRL_ADDR, '0, '1, 32'h01);
    hm.step(1'b0);
    cyc(20);
    apb(1'b0, STATUS_ADDR, '0, 32'h7F, 32'h01);
    lv.disk_in <= 1'b0;
    cyc(8);
    apb(1'b0, STATUS_ADDR, '0, 32'h200, 32'h200);
    lv.spindle_run_request_n <= 1'b0;
    cyc(8);
    `CHK("no spin", 1'b0, mech.spindle_on)
    `CHK("steps left", 0, exp_dir.size())
    summarize();
  end
endmodule
